// ==== dfs_pkg.sv ====
// Constants and carriers for the damping filter switching stage.
// Assumes one 100 MHz clock; all settings and commands arrive as plain ports.
// What this block does
// R01 - Apply new settings only when per-period command count leaves zero while in position.
// R02 - Settings changed outside position control are not applied on a mode change.
// R03 - On a switch, residual command held in the filter is released at once.
// R04 - New settings usable only after a computation delay; switching inside it is held off.
// R05 - Third and fourth frequencies span 0 to 2000; values 0 to 9 disable them.
// R06 - Each width is clamped to the smaller of frequency and 2000 minus frequency.
// R07 - Depth acts on the first damping setting only.
// R08 - Selection 0 allows two active settings; selection 3 picks settings by direction.
// R09 - Depth 0 to 1000; zero is deepest, larger values reduce depth and delay.
// R10 - Filtering acts on the command path only in position control.
// R11 - A disabled or unselected setting passes the command unchanged with no delay.
`default_nettype none
package dfs_pkg;
    // =========================================================
    // Ranges and timing
    localparam logic [10:0] DFS_FREQ_MAX    = 11'h7D0;
    localparam logic [10:0] DFS_FREQ_MIN_ON = 11'h00A;
    localparam logic [9:0]  DFS_DEPTH_MAX   = 10'h3E8;
    localparam logic [9:0]  DFS_WIDTH_MAX   = 10'h3E8;
    localparam int          DFS_CLK_MHZ     = 100;
    localparam int          DFS_PERIOD_NS   = 166000;
    localparam int          DFS_PERIOD_CYC  = DFS_PERIOD_NS * DFS_CLK_MHZ / 1000;
    localparam int          DFS_CALC_US     = 20;
    localparam int          DFS_CALC_CYC    = DFS_CALC_US * DFS_CLK_MHZ;
    localparam logic [1:0]  DFS_SEL_TWO     = 2'h0;
    localparam logic [1:0]  DFS_SEL_DIR     = 2'h3;
    localparam logic [15:0] DFS_CNT_RST     = 16'h0000;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic [10:0] freq;
        logic [9:0]  width;
    } dfs_set_s;

    typedef struct packed {
        dfs_set_s [3:0] set;
        logic [9:0]     depth;
    } dfs_cfg_s;

    typedef enum logic [2:0] {
        DFS_IDLE = 3'b001,
        DFS_CALC = 3'b010,
        DFS_RDY  = 3'b100
    } dfs_state_e;
endpackage
`default_nettype wire

// ==== dfs_damping_switch.sv ====
// Damping filter switching stage on the position command path.
// Assumes inputs synchronous to i_sys_clk; command is a signed pulse count
// delivered once per detection period with i_cmd_valid.
`timescale 1ns/1ps
`default_nettype none
module dfs_damping_switch
    import dfs_pkg::*;
#(
    parameter int CALC_CYC = DFS_CALC_CYC
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_pos_mode,
    input  wire logic              i_pos_complete,
    input  wire logic              i_cmd_valid,
    input  wire logic signed [15:0] i_cmd_pulses,
    input  wire logic              i_cfg_write,
    input  wire logic [1:0]        i_filter_select,
    input  wire logic [10:0]       i_first_damp_freq_setting,
    input  wire logic [9:0]        i_first_damp_width_setting,
    input  wire logic [10:0]       i_second_damp_freq_setting,
    input  wire logic [9:0]        i_second_damp_width_setting,
    input  wire logic [10:0]       i_third_damp_freq_setting,
    input  wire logic [9:0]        i_third_damp_width_setting,
    input  wire logic [10:0]       i_fourth_damp_freq_setting,
    input  wire logic [9:0]        i_fourth_damp_width_setting,
    input  wire logic [9:0]        i_first_damp_depth_setting,
    output logic signed [15:0]     o_cmd_out,
    output logic                   o_cmd_out_valid,
    output logic [3:0]             o_sect_active,
    output logic                   o_switch_pulse,
    output logic                   o_pending,
    output logic [43:0]            o_eff_freq,
    output logic [39:0]            o_eff_width,
    output logic [9:0]             o_eff_depth
);
    // =========================================================
    // State
    typedef struct packed {
        dfs_state_e      st;
        logic [15:0]     calc_cnt;
        logic            prev_zero;
        dfs_cfg_s        shadow;
        dfs_cfg_s        eff;
        logic            shadow_pos;
        logic signed [17:0] resid;
        logic signed [15:0] cmd_out;
        logic            out_valid;
        logic [3:0]      act;
        logic            sw;
        logic            pend;
    } dfs_state_s;

    dfs_state_s state_reg;
    dfs_state_s state_next;
    dfs_cfg_s   cfg_in;
    logic       trigger;
    logic       dir_pos;
    logic [3:0] sel_mask;
    logic [3:0] on_mask;
    logic signed [17:0] held;
    logic signed [17:0] pass;

    // Width clamp to min(freq, 2000-freq)
    function automatic logic [9:0] dfs_clamp(input logic [10:0] f,
                                              input logic [9:0] w);
        logic [10:0] lim;
        lim = (f < DFS_FREQ_MAX - f) ? f : 11'(DFS_FREQ_MAX - f);
        dfs_clamp = ({1'b0, w} > lim) ? lim[9:0] : w; // see R06
    endfunction

    always_comb begin
        cfg_in.set[0] = '{i_first_damp_freq_setting,  i_first_damp_width_setting};
        cfg_in.set[1] = '{i_second_damp_freq_setting, i_second_damp_width_setting};
        cfg_in.set[2] = '{i_third_damp_freq_setting,  i_third_damp_width_setting};
        cfg_in.set[3] = '{i_fourth_damp_freq_setting, i_fourth_damp_width_setting};
        cfg_in.depth  = (i_first_damp_depth_setting > DFS_DEPTH_MAX) ?
                        DFS_DEPTH_MAX : i_first_damp_depth_setting; // see R09
        for (int k = 0; k < 4; k++) begin
            if (cfg_in.set[k].freq > DFS_FREQ_MAX) begin
                cfg_in.set[k].freq = DFS_FREQ_MAX; // see R05
            end
            if (cfg_in.set[k].width > DFS_WIDTH_MAX) begin
                cfg_in.set[k].width = DFS_WIDTH_MAX;
            end
            cfg_in.set[k].width = dfs_clamp(cfg_in.set[k].freq,
                                            cfg_in.set[k].width);
        end
    end

    // Count leaves zero while settled
    assign trigger = i_cmd_valid && state_reg.prev_zero &&
                     (i_cmd_pulses != 16'sh0000) && i_pos_complete &&
                     i_pos_mode; // see R01
    assign dir_pos = !i_cmd_pulses[15];

    always_comb begin
        on_mask = 4'h0;
        for (int k = 0; k < 4; k++) begin
            on_mask[k] = state_reg.eff.set[k].freq >= DFS_FREQ_MIN_ON; // see R05
        end
        if (i_filter_select == DFS_SEL_DIR) begin
            sel_mask = dir_pos ? 4'h5 : 4'hA; // see R08
        end else begin
            // Lowest two enabled sections win
            sel_mask = 4'h0;
            for (int k = 0; k < 4; k++) begin
                if (on_mask[k] && ($countones(sel_mask) < 2)) begin
                    sel_mask[k] = 1'b1; // see R08
                end
            end
        end
    end

    always_comb begin
        state_next     = state_reg;
        state_next.sw  = 1'b0;
        state_next.out_valid = 1'b0;
        held = 18'sh00000;
        pass = 18'sh00000;
        unique case (state_reg.st)
            DFS_IDLE: begin
                if (i_cfg_write) begin
                    state_next.st = DFS_CALC;
                end
            end
            DFS_CALC: begin
                // Switching during the recompute leaves old values in place
                if (state_reg.calc_cnt == 16'(CALC_CYC - 1)) begin
                    state_next.st = DFS_RDY; // see R04
                end
            end
            DFS_RDY: begin
                if (trigger && state_reg.shadow_pos) begin
                    state_next.eff = state_reg.shadow; // see R01
                    state_next.sw  = 1'b1;
                    state_next.st  = DFS_IDLE;
                end
            end
        endcase
        if (i_cfg_write) begin
            state_next.shadow     = cfg_in;
            state_next.shadow_pos = i_pos_mode; // see R02
            state_next.calc_cnt   = DFS_CNT_RST;
            if (state_reg.st != DFS_IDLE) begin
                state_next.st = DFS_CALC;
            end
        end else if (state_reg.st == DFS_CALC) begin
            state_next.calc_cnt = state_reg.calc_cnt + 16'h0001;
        end
        state_next.pend = (state_next.st != DFS_IDLE); // see R04
        if (i_cmd_valid) begin
            state_next.prev_zero = (i_cmd_pulses == 16'sh0000);
            state_next.act = (i_pos_mode) ? (sel_mask & on_mask) : 4'h0;
            if (!i_pos_mode || (state_next.act == 4'h0)) begin
                // Straight through, residue flushed
                pass = 18'(i_cmd_pulses) + state_reg.resid; // see R10 R11
                state_next.resid = 18'sh00000;
            end else if (state_next.sw) begin
                // Flushed command bypasses every section, old or new
                pass = 18'(i_cmd_pulses) + state_reg.resid; // see R03
                state_next.resid = 18'sh00000;
                state_next.act   = 4'h0;
            end else begin
                // Depth 0 holds half, depth max holds nothing: see R07 R09
                held = 18'(((18'(i_cmd_pulses) + state_reg.resid) *
                        $signed({1'b0, DFS_DEPTH_MAX - state_reg.eff.depth}))
                        / 2000);
                if (!state_next.act[0]) begin
                    held = (18'(i_cmd_pulses) + state_reg.resid) >>> 1;
                end
                pass = 18'(i_cmd_pulses) + state_reg.resid - held;
                state_next.resid = held;
            end
            state_next.cmd_out   = 16'(pass);
            state_next.out_valid = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= '{st: DFS_IDLE, calc_cnt: DFS_CNT_RST,
                           prev_zero: 1'b1, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        o_cmd_out       = state_reg.cmd_out;
        o_cmd_out_valid = state_reg.out_valid;
        o_sect_active   = state_reg.act;
        o_switch_pulse  = state_reg.sw;
        o_pending       = state_reg.pend;
        o_eff_depth     = state_reg.eff.depth;
        for (int k = 0; k < 4; k++) begin
            o_eff_freq[k*11 +: 11] = state_reg.eff.set[k].freq;
            o_eff_width[k*10 +: 10] = state_reg.eff.set[k].width;
        end
    end

    // =========================================================
    // Checks
    AST_SW_NEEDS_TRIG: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) o_switch_pulse |-> $past(o_pending &&
        i_cmd_valid && i_pos_complete && i_pos_mode &&
        (i_cmd_pulses != 16'sh0000))) // see R01
        else $error("switch without trigger");
    AST_NO_SW_CALC: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) (state_reg.st == DFS_CALC) |=> !o_switch_pulse) // see R04
        else $error("switch during recompute");
    AST_FLUSH: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) o_switch_pulse |-> state_reg.resid == 18'sh0) // see R03
        else $error("residue kept at switch");
    AST_SEL_DIR: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) ##1 ($past(i_filter_select) == DFS_SEL_DIR &&
        $past(i_cmd_valid)) |-> (o_sect_active & 4'hA) == 4'h0 ||
        (o_sect_active & 4'h5) == 4'h0) // see R08
        else $error("direction selection mixed");
    AST_MAX_TWO: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) $countones(o_sect_active) <= 2) // see R08
        else $error("too many sections");
    AST_POS_ONLY: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) (i_cmd_valid && !i_pos_mode) |=>
        o_sect_active == 4'h0) // see R10
        else $error("filter outside position mode");
    AST_WIDTH_CLAMP: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) {1'b0, o_eff_width[9:0]} <= o_eff_freq[10:0]) // see R06
        else $error("width not clamped");
    AST_DISABLED: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b) (o_eff_freq[32:22] < DFS_FREQ_MIN_ON) |->
        !o_sect_active[2]) // see R05
        else $error("disabled section active");

    // Write taken, then the recompute window starts
    sequence dfs_seq_write_taken;
        i_cfg_write ##1 o_pending;
    endsequence

    // Holds for any recompute delay of three cycles or more
    AST_HOLD_AFTER_WR: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_b)
        dfs_seq_write_taken |=> !o_switch_pulse [*3]) // see R04
        else $error("switch inside recompute delay");
endmodule // dfs_damping_switch
`default_nettype wire

// ==== dfs_host_model.sv ====
// Host motion controller model: issues one position command per request.
// Assumes the bench raises i_go for one cycle between falling edges.
`timescale 1ns/1ps
`default_nettype none
module dfs_host_model (
    input  wire logic               i_sys_clk,
    input  wire logic               i_go,
    input  wire logic signed [15:0] i_value,
    output logic                    o_cmd_valid,
    output logic signed [15:0]      o_cmd_pulses
);
    logic signed [15:0] last_reg = 16'h0000;
    // Idle count toggles, so a stale value never passes for a command
    assign o_cmd_valid  = i_go;
    assign o_cmd_pulses = i_go ? i_value : ~last_reg;
    always_ff @(posedge i_sys_clk) begin
        last_reg <= o_cmd_pulses;
    end
endmodule // dfs_host_model
`default_nettype wire

// ==== damping_filter_switching_tb_top.sv ====
// Self-checking bench for the damping filter switching stage.
// Assumes the host model supplies commands; settings are driven here.
`timescale 1ns/1ps
`default_nettype none
module damping_filter_switching_tb_top;
    import dfs_pkg::*;
    localparam int CALC = 8;
    logic clk, rst_b, pos_mode, pos_cmp, wr, go, cv, cvalid, swp, pend, s;
    logic [1:0] sel;
    logic [10:0] fr [4];
    logic [9:0] wd [4];
    logic [9:0] dep, edep;
    logic signed [15:0] val, cp, cout, v;
    logic [3:0] act;
    logic [43:0] efreq, old;
    logic [39:0] ewid;
    int failures = 0, comparisons = 0, seed = 32'hd952;
    // Running sums: a filter may delay pulses but never lose them
    logic signed [31:0] sum_in = 32'h0, sum_out = 32'h0, res;
    always #5 clk = ~clk;
    dfs_host_model host (.i_sys_clk(clk), .i_go(go), .i_value(val),
        .o_cmd_valid(cv), .o_cmd_pulses(cp));
    dfs_damping_switch #(.CALC_CYC(CALC)) uut (.i_sys_clk(clk),
        .i_rst_b(rst_b), .i_pos_mode(pos_mode), .i_pos_complete(pos_cmp),
        .i_cmd_valid(cv), .i_cmd_pulses(cp), .i_cfg_write(wr),
        .i_filter_select(sel), .i_first_damp_freq_setting(fr[0]),
        .i_first_damp_width_setting(wd[0]),
        .i_second_damp_freq_setting(fr[1]),
        .i_second_damp_width_setting(wd[1]),
        .i_third_damp_freq_setting(fr[2]),
        .i_third_damp_width_setting(wd[2]),
        .i_fourth_damp_freq_setting(fr[3]),
        .i_fourth_damp_width_setting(wd[3]),
        .i_first_damp_depth_setting(dep), .o_cmd_out(cout),
        .o_cmd_out_valid(cvalid), .o_sect_active(act),
        .o_switch_pulse(swp), .o_pending(pend), .o_eff_freq(efreq),
        .o_eff_width(ewid), .o_eff_depth(edep));
    // =========================================================
    // Helpers
    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t exp=%0h got=%0h", $time, exp, got);
        end
    endtask
    task automatic send(input logic signed [15:0] x, output logic sw);
        @(negedge clk);
        go = 1'b1;
        val = x;
        @(negedge clk);
        go = 1'b0;
        sw = swp;
        sum_in = sum_in + x;
        sum_out = sum_out + cout;
        chk(cvalid, 1'b1);
    endtask
    task automatic trig(output logic sw);
        send(16'sh0000, sw);
        send(16'sh0010, sw);
    endtask
    function automatic logic [10:0] fc(input logic [10:0] f);
        return (f > 11'h7D0) ? 11'h7D0 : f;
    endfunction
    function automatic logic [9:0] ew(input logic [10:0] f, input logic [9:0] w);
        logic [10:0] a, lim;
        a = fc(f);
        lim = (a < 11'h7D0 - a) ? a : 11'h7D0 - a;
        return ({1'b0, w} < lim) ? w : lim[9:0];
    endfunction
    function automatic logic [3:0] eact(input logic [1:0] sl, input logic p);
        logic [3:0] en, r;
        int n;
        r = 4'h0;
        n = 0;
        for (int k = 0; k < 4; k++) en[k] = fc(fr[k]) >= 11'h00A;
        if (sl == 2'h3) return en & (p ? 4'h5 : 4'hA);
        // Selection 0 keeps the two lowest enabled sections
        for (int k = 0; k < 4; k++) if (en[k] && n < 2) begin
            r[k] = 1'b1;
            n++;
        end
        return r;
    endfunction
    task automatic end_of_test;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // =========================================================
    // Main sequence
    initial begin
        clk = 1'b0; rst_b = 1'b0; pos_mode = 1'b1; pos_cmp = 1'b1;
        wr = 1'b0; sel = 2'h0; dep = 10'h000; go = 1'b0; val = 16'h0000;
        foreach (fr[k]) begin
            fr[k] = 11'h000;
            wd[k] = 10'h000;
        end
        repeat (5) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        chk(pend, 1'b0);
        chk(efreq, 44'h0);
        repeat (6) begin
            v = 16'($random(seed));
            send(v, s);
            chk(cout, v);
        end
        for (int r = 0; r < 2; r++) begin
            sel = r ? 2'h3 : 2'h0;
            foreach (fr[k]) begin
                fr[k] = 11'h00A + 11'($unsigned($random(seed)) % 1991);
                wd[k] = 10'($unsigned($random(seed)) % 1001);
            end
            if (r == 0) begin
                fr[0] = 11'h005;
                fr[3] = 11'h7C6;
            end else begin
                // Above range: clamps to the top, width collapses to zero
                fr[2] = 11'h7FF;
            end
            dep = 10'($unsigned($random(seed)) % 1001);
            @(negedge clk) wr = 1'b1;
            @(negedge clk) wr = 1'b0;
            trig(s);
            chk(s, 1'b0);
            chk(pend, 1'b1);
            repeat (CALC + 4) @(negedge clk);
            pos_cmp = 1'b0;
            trig(s);
            chk(s, 1'b0);
            pos_cmp = 1'b1;
            send(16'sh0010, s);
            chk(s, 1'b0);
            trig(s);
            chk(s, 1'b1);
            chk(sum_out, sum_in);
            chk(pend, 1'b0);
            for (int k = 0; k < 4; k++) begin
                chk(efreq[k*11+:11], fc(fr[k]));
                chk(ewid[k*10+:10], ew(fr[k], wd[k]));
            end
            chk(edep, dep);
            send(16'sh0005, s);
            chk(act, eact(sel, 1'b1));
            send(-16'sh0005, s);
            chk(act, eact(sel, 1'b0));
        end
        // Settings written outside position control must stay unused
        pos_mode = 1'b0;
        old = efreq;
        fr[1] = fr[1] ^ 11'h001;
        @(negedge clk) wr = 1'b1;
        @(negedge clk) wr = 1'b0;
        repeat (CALC + 4) @(negedge clk);
        v = 16'($random(seed));
        // Leaving position control releases whatever residue is held
        res = sum_in - sum_out;
        send(v, s);
        chk(cout, 16'(v + res));
        pos_mode = 1'b1;
        trig(s);
        chk(s, 1'b0);
        chk(efreq, old);
        end_of_test();
    end
    initial begin
        #300000;
        failures++;
        end_of_test();
    end
endmodule // damping_filter_switching_tb_top
`default_nettype wire
